// File: verilog/ccc_capture_compare_block.sv
// Purpose: Sixteen-channel capture/compare block with two reloadable timers.
// Assumes: All inputs synchronous to i_clock; plain register port with 1-cycle read data.
// Notes:   Channel k and k+8 share pin k in double-register operation.
`timescale 1ns/100ps
module ccc_capture_compare_block #(
  parameter int NUM_CH = ccc_pkg::CCC_CHANNELS
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_rst_n,
  input  wire logic [ccc_pkg::CCC_AW-1:0] i_addr,
  input  wire logic [ccc_pkg::CCC_DW-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [ccc_pkg::CCC_DW-1:0] o_rdata,
  input  wire logic [NUM_CH-1:0]          i_pin,
  output logic      [NUM_CH-1:0]          o_pin,
  output logic      [NUM_CH-1:0]          o_pin_oe,
  input  wire logic                       i_sixth_general_timer_ovf,
  input  wire logic [1:0]                 i_ext_count,
  output logic                            o_irq
);

  localparam int TW   = ccc_pkg::CCC_TW;
  localparam int HALF = NUM_CH / 2;

  ccc_pkg::ccc_tctl_s  tctl_reg     [2];
  logic [TW-1:0]       timer_reg    [2];
  logic [TW-1:0]       reload_reg   [2];
  logic                stagger_reg;
  logic [2:0]          stag_cnt_reg;
  logic [7:0]          div_reg;
  logic [1:0]          ext_prev_reg;
  logic [1:0]          counted_reg;
  logic [1:0]          tick;
  logic [1:0]          ovf;
  logic                base_tick;
  ccc_pkg::ccc_chctl_s ctl_reg      [NUM_CH];
  logic [TW-1:0]       val_reg      [NUM_CH];
  logic [NUM_CH-1:0]   pin_prev_reg;
  logic [NUM_CH-1:0]   pin_reg;
  logic [NUM_CH-1:0]   armed_reg;
  logic [NUM_CH-1:0]   done_reg;
  logic [NUM_CH-1:0]   cap_evt;
  logic [NUM_CH-1:0]   act;
  logic [NUM_CH-1:0]   status_reg;
  logic [NUM_CH-1:0]   enable_reg;
  logic [31:0]         rdata_reg;
  logic [3:0]          idx;
  logic                wr_ctl;
  logic                wr_val;

  assign idx    = i_addr[5:2];
  assign wr_ctl = i_wr && (i_addr[7:6] == ccc_pkg::CCC_PAGE_CH_CTL);
  assign wr_val = i_wr && (i_addr[7:6] == ccc_pkg::CCC_PAGE_CH_VAL);

  // ==========================================================================
  // Base tick and shared prescaler

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      stag_cnt_reg <= 3'h0;
    else
      stag_cnt_reg <= stag_cnt_reg + 3'h1;
  end

  // Staggered operation stretches the finest step to eight clocks.
  assign base_tick = !stagger_reg || (stag_cnt_reg == 3'(ccc_pkg::CCC_STAGGER_CYCLES - 1));

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      div_reg <= 8'h00;
    else if (base_tick)
      div_reg <= div_reg + 8'h01;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      ext_prev_reg <= 2'h0;
    else
      ext_prev_reg <= i_ext_count;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      tctl_reg[0] <= ccc_pkg::CCC_TCTL_RST;
      tctl_reg[1] <= ccc_pkg::CCC_TCTL_RST;
      stagger_reg <= 1'b0;
    end
    else if (i_wr && i_addr == ccc_pkg::CCC_OFF_TCTL)
    begin
      tctl_reg[0] <= i_wdata[5:0];
      tctl_reg[1] <= i_wdata[ccc_pkg::CCC_TCTL_T1_POS +: 6];
      stagger_reg <= i_wdata[ccc_pkg::CCC_TCTL_STAG_POS];
    end
  end

  // ==========================================================================
  // Timers

  for (genvar t = 0; t < 2; t++)
  begin : g_timer
    logic [7:0] mask;
    logic       src_tick;
    logic [7:0] off_timer;
    logic [7:0] off_reload;

    assign off_timer  = (t == 0) ? ccc_pkg::CCC_OFF_TIMER0 : ccc_pkg::CCC_OFF_TIMER1;
    assign off_reload = (t == 0) ? ccc_pkg::CCC_OFF_RELOAD0 : ccc_pkg::CCC_OFF_RELOAD1;
    assign mask       = ~(8'hff << tctl_reg[t].psel);

    always_comb
    begin
      case (tctl_reg[t].src)
        ccc_pkg::CCC_SRC_PRESCALE: src_tick = base_tick && ((div_reg & mask) == mask);
        ccc_pkg::CCC_SRC_GENTIMER: src_tick = i_sixth_general_timer_ovf;
        ccc_pkg::CCC_SRC_EXTERNAL: src_tick = i_ext_count[t] && !ext_prev_reg[t];
        default:                   src_tick = 1'b0;
      endcase
    end

    assign tick[t] = tctl_reg[t].run && src_tick;
    assign ovf[t]  = tick[t] && (timer_reg[t] == '1);

    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
        reload_reg[t] <= ccc_pkg::CCC_TW_RST;
      else if (i_wr && i_addr == off_reload)
        reload_reg[t] <= i_wdata[TW-1:0];
    end

    // A software write to the count wins over a tick in the same cycle.
    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
        timer_reg[t] <= ccc_pkg::CCC_TW_RST;
      else if (i_wr && i_addr == off_timer)
        timer_reg[t] <= i_wdata[TW-1:0];
      else if (ovf[t])
        timer_reg[t] <= reload_reg[t];
      else if (tick[t])
        timer_reg[t] <= timer_reg[t] + 16'h0001;
    end

    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
        counted_reg[t] <= 1'b0;
      else
        counted_reg[t] <= tick[t];
    end
  end

  // ==========================================================================
  // Channels

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      pin_prev_reg <= '0;
    else
      pin_prev_reg <= i_pin;
  end

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    logic [TW-1:0] tval;
    logic          tcnt;
    logic          tovf;
    logic          rise;
    logic          fall;
    logic          is_cmp;
    logic          once;
    logic          match;
    logic          partner;
    logic          toggle;
    logic          sel_wr;

    assign sel_wr = (idx == 4'(i));
    assign tval   = ctl_reg[i].timer_sel ? timer_reg[1] : timer_reg[0];
    assign tcnt   = ctl_reg[i].timer_sel ? counted_reg[1] : counted_reg[0];
    assign tovf   = ctl_reg[i].timer_sel ? ovf[1] : ovf[0];
    assign rise   = i_pin[i] && !pin_prev_reg[i];
    assign fall   = !i_pin[i] && pin_prev_reg[i];
    assign is_cmp = ctl_reg[i].mode[2];
    assign once   = (ctl_reg[i].mode == ccc_pkg::CCC_MODE_CMP2) || (ctl_reg[i].mode == ccc_pkg::CCC_MODE_CMP3);

    always_comb
    begin
      case (ctl_reg[i].mode)
        ccc_pkg::CCC_MODE_CAP_RISE: cap_evt[i] = rise;
        ccc_pkg::CCC_MODE_CAP_FALL: cap_evt[i] = fall;
        ccc_pkg::CCC_MODE_CAP_BOTH: cap_evt[i] = rise || fall;
        default:                    cap_evt[i] = 1'b0;
      endcase
    end

    // The compare runs one clock after each count, against the new timer value.
    assign match  = is_cmp && tcnt && (tval == val_reg[i]);
    assign act[i] = match && (armed_reg[i] || !ctl_reg[i].single_evt) && !(once && done_reg[i]);

    if (i < HALF)
    begin : g_lo
      assign partner = ctl_reg[i].double_pin && act[i + HALF];
    end
    else
    begin : g_hi
      assign partner = 1'b0;
    end

    assign toggle = (act[i] && (ctl_reg[i].mode == ccc_pkg::CCC_MODE_CMP1 || ctl_reg[i].double_pin)) || partner;

    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
        ctl_reg[i] <= ccc_pkg::CCC_CHCTL_RST;
      else if (wr_ctl && sel_wr)
        ctl_reg[i] <= i_wdata[5:0];
    end

    // Capture wins over a software write in the same cycle.
    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
        val_reg[i] <= ccc_pkg::CCC_TW_RST;
      else if (cap_evt[i])
        val_reg[i] <= tval;
      else if (wr_val && sel_wr)
        val_reg[i] <= i_wdata[TW-1:0];
    end

    // Writing the control word re-arms the channel.
    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
        armed_reg[i] <= 1'b0;
      else if (wr_ctl && sel_wr)
        armed_reg[i] <= 1'b1;
      else if (act[i] && ctl_reg[i].single_evt)
        armed_reg[i] <= 1'b0;
    end

    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
        done_reg[i] <= 1'b0;
      else if (act[i])
        done_reg[i] <= 1'b1;
      else if (tovf || (wr_ctl && sel_wr))
        done_reg[i] <= 1'b0;
    end

    // Mode 0 and mode 2 touch the pin level only in double-register operation.
    always_ff @(posedge i_clock)
    begin
      if (!i_rst_n)
        pin_reg[i] <= 1'b0;
      else if (act[i] && ctl_reg[i].mode == ccc_pkg::CCC_MODE_CMP3)
        pin_reg[i] <= 1'b1;
      else if (toggle)
        pin_reg[i] <= !pin_reg[i];
      else if (tovf && ctl_reg[i].mode == ccc_pkg::CCC_MODE_CMP3 && !ctl_reg[i].double_pin)
        pin_reg[i] <= 1'b0;
    end

    assign o_pin_oe[i] = is_cmp && (ctl_reg[i].mode[0] || ctl_reg[i].double_pin);
  end

  assign o_pin = pin_reg;

  // ==========================================================================
  // Interrupt status

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      status_reg <= '0;
    else if (i_wr && i_addr == ccc_pkg::CCC_OFF_IRQ_CLEAR)
      status_reg <= (status_reg & ~i_wdata[NUM_CH-1:0]) | cap_evt | act;
    else
      status_reg <= status_reg | cap_evt | act;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      enable_reg <= '0;
    else if (i_wr && i_addr == ccc_pkg::CCC_OFF_IRQ_ENABLE)
      enable_reg <= i_wdata[NUM_CH-1:0];
  end

  assign o_irq = |(status_reg & enable_reg);

  // ==========================================================================
  // Read port

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      rdata_reg <= 32'h0000_0000;
    else if (!i_rd)
      rdata_reg <= 32'h0000_0000;
    else if (i_addr[7:6] == ccc_pkg::CCC_PAGE_CH_CTL && 32'(idx) < NUM_CH)
      rdata_reg <= {24'h00_0000, pin_reg[idx], armed_reg[idx], ctl_reg[idx]};
    else if (i_addr[7:6] == ccc_pkg::CCC_PAGE_CH_VAL && 32'(idx) < NUM_CH)
      rdata_reg <= {16'h0000, val_reg[idx]};
    else
    begin
      case (i_addr)
        ccc_pkg::CCC_OFF_TIMER0:     rdata_reg <= {16'h0000, timer_reg[0]};
        ccc_pkg::CCC_OFF_TIMER1:     rdata_reg <= {16'h0000, timer_reg[1]};
        ccc_pkg::CCC_OFF_RELOAD0:    rdata_reg <= {16'h0000, reload_reg[0]};
        ccc_pkg::CCC_OFF_RELOAD1:    rdata_reg <= {16'h0000, reload_reg[1]};
        ccc_pkg::CCC_OFF_TCTL:       rdata_reg <= {15'h0000, stagger_reg, 2'h0, tctl_reg[1], 2'h0, tctl_reg[0]};
        ccc_pkg::CCC_OFF_IRQ_STATUS: rdata_reg <= 32'(status_reg);
        ccc_pkg::CCC_OFF_IRQ_ENABLE: rdata_reg <= 32'(enable_reg);
        default:                     rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign o_rdata = rdata_reg;

  // ==========================================================================
  // Assertions

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  property p_stagger;
    stagger_reg && base_tick && !(i_wr && i_addr == ccc_pkg::CCC_OFF_TCTL) |=> !base_tick [*7];
  endproperty
  a_stagger: assert property (p_stagger) else $error("Staggered base tick came early.");

  property p_count;
    tick[0] && !ovf[0] && !(i_wr && i_addr == ccc_pkg::CCC_OFF_TIMER0) |=> timer_reg[0] == $past(timer_reg[0]) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("Timer 0 did not step by one.");

  property p_reload;
    ovf[0] && !(i_wr && i_addr == ccc_pkg::CCC_OFF_TIMER0) |=> timer_reg[0] == $past(reload_reg[0]);
  endproperty
  a_reload: assert property (p_reload) else $error("Timer 0 did not reload on overflow.");

  property p_capture;
    cap_evt[5] |=> val_reg[5] == $past(g_ch[5].tval) && status_reg[5];
  endproperty
  a_capture: assert property (p_capture) else $error("Capture value or request missing.");

  property p_toggle;
    act[0] && ctl_reg[0].mode == ccc_pkg::CCC_MODE_CMP1 && !g_ch[0].partner |=> o_pin[0] != $past(o_pin[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("Mode 1 pin did not toggle.");

  property p_mode3;
    act[3] && ctl_reg[3].mode == ccc_pkg::CCC_MODE_CMP3 |=> o_pin[3] ##1 !act[3] [*2];
  endproperty
  a_mode3: assert property (p_mode3) else $error("Mode 3 set or once-per-period failed.");

  property p_quiet;
    ctl_reg[1].mode == ccc_pkg::CCC_MODE_CMP0 && !ctl_reg[1].double_pin && !(wr_ctl && idx == 4'h1)
      |=> $stable(o_pin[1]) && !o_pin_oe[1];
  endproperty
  a_quiet: assert property (p_quiet) else $error("Mode 0 moved the pin.");

  property p_single;
    act[4] && ctl_reg[4].single_evt && !(wr_ctl && idx == 4'h4) |=> !armed_reg[4] ##1 !act[4];
  endproperty
  a_single: assert property (p_single) else $error("Single event fired twice.");

  property p_irq;
    ((cap_evt | act) & enable_reg) != '0 && !(i_wr && i_addr == ccc_pkg::CCC_OFF_IRQ_ENABLE) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Enabled event did not raise the interrupt.");

  c_capture: cover property (cap_evt[5] ##1 o_irq);
  c_toggle:  cover property (act[0] && ctl_reg[0].mode == ccc_pkg::CCC_MODE_CMP1);
  c_double:  cover property (g_ch[1].partner);
  c_stagger: cover property (tick[0] && stagger_reg);

endmodule

// File: verilog/ccc_pkg.sv
// Purpose: Constants, register map and field layouts of the capture/compare block.
// Assumes: 32-bit plain register port, byte addresses, one word per register.
// Notes:   Each rule below is tagged where the logic carries it out.
package ccc_pkg;

  // ==========================================================================
  // Sizes and timing
  localparam int CCC_CHANNELS       = 16;
  localparam int CCC_TW             = 16;
  localparam int CCC_AW             = 8;
  localparam int CCC_DW             = 32;
  localparam int CCC_STAGGER_CYCLES = 8;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CCC_OFF_TIMER0     = 8'h00;
  localparam logic [7:0] CCC_OFF_TIMER1     = 8'h04;
  localparam logic [7:0] CCC_OFF_RELOAD0    = 8'h08;
  localparam logic [7:0] CCC_OFF_RELOAD1    = 8'h0c;
  localparam logic [7:0] CCC_OFF_TCTL       = 8'h10;
  localparam logic [7:0] CCC_OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] CCC_OFF_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] CCC_OFF_IRQ_CLEAR  = 8'h1c;
  localparam logic [1:0] CCC_PAGE_CH_CTL    = 2'h1;
  localparam logic [1:0] CCC_PAGE_CH_VAL    = 2'h2;

  // Timer control word: timer 0 in bits 5:0, timer 1 in bits 13:8, stagger bit 16.
  localparam int CCC_TCTL_T1_POS   = 8;
  localparam int CCC_TCTL_STAG_POS = 16;
  // Channel control word: fields in bits 5:0, armed flag 6, pin level 7.
  localparam int CCC_CHCTL_ARM_POS = 6;
  localparam int CCC_CHCTL_PIN_POS = 7;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] CCC_SRC_PRESCALE = 2'h0;
  localparam logic [1:0] CCC_SRC_GENTIMER = 2'h1;
  localparam logic [1:0] CCC_SRC_EXTERNAL = 2'h2;

  localparam logic [2:0] CCC_MODE_OFF      = 3'h0;
  localparam logic [2:0] CCC_MODE_CAP_RISE = 3'h1;
  localparam logic [2:0] CCC_MODE_CAP_FALL = 3'h2;
  localparam logic [2:0] CCC_MODE_CAP_BOTH = 3'h3;
  localparam logic [2:0] CCC_MODE_CMP0     = 3'h4;
  localparam logic [2:0] CCC_MODE_CMP1     = 3'h5;
  localparam logic [2:0] CCC_MODE_CMP2     = 3'h6;
  localparam logic [2:0] CCC_MODE_CMP3     = 3'h7;

  typedef struct packed {
    logic [1:0] src;
    logic [2:0] psel;
    logic       run;
  } ccc_tctl_s;

  typedef struct packed {
    logic       double_pin;
    logic       single_evt;
    logic       timer_sel;
    logic [2:0] mode;
  } ccc_chctl_s;

  // ==========================================================================
  // Reset values
  localparam ccc_tctl_s   CCC_TCTL_RST  = '0;
  localparam ccc_chctl_s  CCC_CHCTL_RST = '0;
  localparam logic [15:0] CCC_TW_RST    = 16'h0000;

endpackage

// File: verification/ccc_pin_model.sv
// Purpose: Port pin model for the sixteen capture/compare channel pins.
// Assumes: The far side drives a pin only while the block leaves it undriven.
// Notes:   A released pin follows the level that the bench commands.
`timescale 1ns/100ps
module ccc_pin_model (
  input  wire logic [15:0] i_level,
  input  wire logic [15:0] i_o_pin,
  input  wire logic [15:0] i_oe,
  output logic      [15:0] o_wire
);
  // ==========================================================================
  // Wire resolution
  // One wire per channel carries both the trigger input and the event output.
  assign o_wire = (i_oe & i_o_pin) | (~i_oe & i_level);
endmodule

// File: verification/testbench.sv
// Purpose: Self-checking bench for the capture/compare block.
// Assumes: Compare tests count external edges so every compare instant is exact.
// Notes:   All waits are fixed counts; settle() is taken from the pin update latency.
`timescale 1ns/100ps
module testbench;
  localparam logic [7:0] TM0 = ccc_pkg::CCC_OFF_TIMER0;
  localparam logic [7:0] TM1 = ccc_pkg::CCC_OFF_TIMER1;
  localparam logic [7:0] RL0 = ccc_pkg::CCC_OFF_RELOAD0;
  localparam logic [7:0] RL1 = ccc_pkg::CCC_OFF_RELOAD1;
  localparam logic [7:0] TCT = ccc_pkg::CCC_OFF_TCTL;
  localparam logic [7:0] IST = ccc_pkg::CCC_OFF_IRQ_STATUS;
  localparam logic [7:0] IEN = ccc_pkg::CCC_OFF_IRQ_ENABLE;
  localparam logic [7:0] ICL = ccc_pkg::CCC_OFF_IRQ_CLEAR;
  localparam logic [7:0] RST_A [11] = '{TM0, TM1, RL0, RL1, TCT, IST, IEN, ICL, 8'h40, 8'h80, 8'h3c};

  logic        i_clock = 1'b0;
  logic        i_rst_n;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic [15:0] pin_wire;
  logic [15:0] pin_level;
  logic [15:0] o_pin;
  logic [15:0] o_pin_oe;
  logic        gen_ovf;
  logic [1:0]  ext_cnt;
  logic        o_irq;
  int          num_errors = 0;
  int          compares = 0;
  logic [31:0] t_first;
  logic [31:0] t_second;

  always #2 i_clock = ~i_clock;

  ccc_capture_compare_block ccc_capture_compare_block_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(pin_wire), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .i_sixth_general_timer_ovf(gen_ovf), .i_ext_count(ext_cnt), .o_irq(o_irq));

  ccc_pin_model ccc_pin_model_i (.i_level(pin_level), .i_o_pin(o_pin), .i_oe(o_pin_oe), .o_wire(pin_wire));

  // ==========================================================================
  // Bus and check tasks
  task automatic close_out();
    $display("Checks made %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask

  task automatic rdv(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] v;
    rdv(a, v);
    chk(n, e, v);
  endtask

  task automatic settle();
    repeat (4) @(posedge i_clock);
    #1;
  endtask

  // One external count edge on timer t, then time for compare and pin update.
  task automatic tick(input int t);
    @(posedge i_clock);
    ext_cnt[t] <= 1'b1;
    @(posedge i_clock);
    ext_cnt[t] <= 1'b0;
    settle();
  endtask

  task automatic pins(input logic [15:0] e, input logic [15:0] eoe);
    chk("o_pin", {16'h0, e}, {16'h0, o_pin});
    chk("o_pin_oe", {16'h0, eoe}, {16'h0, o_pin_oe});
  endtask

  initial
  begin
    #400000;
    num_errors++;
    $display("ERROR watchdog expected end seen timeout");
    close_out();
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    i_rst_n   = 1'b0;
    i_addr    = 8'h00;
    i_wdata   = 32'h0;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    pin_level = 16'h0000;
    gen_ovf   = 1'b0;
    ext_cnt   = 2'h0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    foreach (RST_A[k]) rchk(RST_A[k], 32'h0, "reset value");
    pins(16'h0000, 16'h0000);
    chk("o_irq", 32'h0, {31'h0, o_irq});
    $display("TEST reset done");

    wr(TCT, 32'h0000_2121);
    wr(RL0, 32'h0000_1234);
    wr(TM0, 32'h0000_fffe);
    tick(0);
    rchk(TM0, 32'h0000_ffff, "timer0 count");
    tick(0);
    rchk(TM0, 32'h0000_1234, "timer0 reload");
    tick(0);
    rchk(TM0, 32'h0000_1235, "timer0 after reload");
    rchk(TM1, 32'h0000_0000, "timer1 idle");
    $display("TEST timers done");

    wr(IEN, 32'h0000_ffff);
    wr(8'h40, 32'h5);
    wr(8'h80, 32'h5);
    wr(TM0, 32'h4);
    tick(0);
    pins(16'h0001, 16'h0001);
    rchk(IST, 32'h1, "mode1 status");
    chk("o_irq", 32'h1, {31'h0, o_irq});
    wr(ICL, 32'h1);
    #1;
    chk("o_irq", 32'h0, {31'h0, o_irq});
    wr(TM0, 32'h4);
    tick(0);
    pins(16'h0000, 16'h0001);
    $display("TEST mode1 done");

    wr(ICL, 32'hffff);
    wr(8'h44, 32'hc);
    wr(8'h84, 32'h10);
    wr(TM1, 32'hf);
    tick(1);
    pins(16'h0000, 16'h0001);
    rchk(IST, 32'h2, "mode0 status");
    wr(IEN, 32'hfffd);
    #1;
    chk("o_irq masked", 32'h0, {31'h0, o_irq});
    wr(ICL, 32'h2);
    wr(TM1, 32'hf);
    tick(1);
    rchk(IST, 32'h2, "mode0 second");
    $display("TEST mode0 done");

    wr(ICL, 32'hffff);
    wr(8'h48, 32'h6);
    wr(8'h88, 32'h20);
    wr(TM0, 32'h1f);
    tick(0);
    rchk(IST, 32'h4, "mode2 first");
    wr(ICL, 32'h4);
    wr(TM0, 32'h1f);
    tick(0);
    rchk(IST, 32'h0, "mode2 second");
    pins(16'h0000, 16'h0001);
    $display("TEST mode2 done");

    wr(RL0, 32'h0);
    wr(8'h4c, 32'h7);
    wr(8'h8c, 32'hffff);
    wr(TM0, 32'hfffe);
    tick(0);
    pins(16'h0008, 16'h0009);
    wr(ICL, 32'hffff);
    wr(TM0, 32'hfffe);
    tick(0);
    rchk(IST, 32'h0, "mode3 second");
    tick(0);
    pins(16'h0000, 16'h0009);
    $display("TEST mode3 done");

    wr(8'h50, 32'h15);
    wr(8'h90, 32'h30);
    wr(TM0, 32'h2f);
    tick(0);
    pins(16'h0010, 16'h0019);
    wr(TM0, 32'h2f);
    tick(0);
    pins(16'h0010, 16'h0019);
    wr(8'h50, 32'h15);
    wr(TM0, 32'h2f);
    tick(0);
    pins(16'h0000, 16'h0019);
    $display("TEST single done");

    wr(ICL, 32'hffff);
    wr(8'h54, 32'h9);
    wr(8'h58, 32'ha);
    wr(8'h5c, 32'hb);
    wr(TM1, 32'h42);
    @(posedge i_clock);
    pin_level <= 16'h00e0;
    settle();
    rchk(8'h94, 32'h42, "capture rise");
    rchk(8'h98, 32'h0, "capture fall on rise");
    rchk(8'h9c, 32'h42, "capture both rise");
    rchk(IST, 32'ha0, "capture status");
    wr(ICL, 32'hffff);
    wr(TM1, 32'h77);
    @(posedge i_clock);
    pin_level <= 16'h0000;
    settle();
    rchk(8'h94, 32'h42, "capture rise on fall");
    rchk(8'h98, 32'h77, "capture fall");
    rchk(8'h9c, 32'h77, "capture both fall");
    rchk(IST, 32'hc0, "capture status fall");
    $display("TEST capture done");

    wr(8'h44, 32'h24);
    wr(8'h64, 32'hd);
    wr(8'ha4, 32'h60);
    wr(TM1, 32'h5f);
    tick(1);
    chk("double pin", 32'h1, {31'h0, o_pin[1]});
    chk("double oe", 32'h1, {31'h0, o_pin_oe[1]});
    $display("TEST double done");

    wr(TCT, 32'h0000_1121);
    wr(TM1, 32'h100);
    @(posedge i_clock);
    gen_ovf <= 1'b1;
    repeat (3) @(posedge i_clock);
    gen_ovf <= 1'b0;
    tick(1);
    rchk(TM1, 32'h103, "timer1 general source");
    $display("TEST source done");

    // Prescaled source with psel 1 under stagger: one count every 16 clocks.
    // Two reads 160 sampling edges apart see exactly ten counts, whatever the phase.
    wr(TCT, 32'h0001_0003);
    rdv(TM0, t_first);
    repeat (158) @(posedge i_clock);
    rdv(TM0, t_second);
    chk("stagger prescale counts", 32'ha, t_second - t_first);
    $display("TEST stagger done");
    close_out();
  end
endmodule
